// [hw/acd_regs.vh]
// Purpose : constants for the command protocol decoder
// Assumes : 8-bit command and feature codes from the task interface
// Notes   : definitions only
`ifndef ACD_REGS_VH
`define ACD_REGS_VH

// ****************************************************************
// protocol class codes
// ****************************************************************
`define ACD_CLS_NONDATA   3'h0
`define ACD_CLS_PIO_IN    3'h1
`define ACD_CLS_PIO_OUT   3'h2
`define ACD_CLS_DMA       3'h3
`define ACD_CLS_DIAG      3'h4
`define ACD_CLS_ABORT     3'h5

// ****************************************************************
// general feature set opcodes
// ****************************************************************
`define ACD_OP_NOP        8'h00
`define ACD_OP_RD_SEC0    8'h20
`define ACD_OP_RD_SEC1    8'h21
`define ACD_OP_WR_SEC0    8'h30
`define ACD_OP_WR_SEC1    8'h31
`define ACD_OP_VFY0       8'h40
`define ACD_OP_VFY1       8'h41
`define ACD_OP_DIAG       8'h90
`define ACD_OP_RD_MULT    8'hC4
`define ACD_OP_WR_MULT    8'hC5
`define ACD_OP_SET_MULT   8'hC6
`define ACD_OP_RD_DMA     8'hC8
`define ACD_OP_WR_DMA     8'hCA
`define ACD_OP_RD_BUF     8'hE4
`define ACD_OP_FLUSH      8'hE7
`define ACD_OP_WR_BUF     8'hE8
`define ACD_OP_IDENT      8'hEC
`define ACD_OP_SET_FEAT   8'hEF

// ****************************************************************
// power management opcodes, new and legacy forms
// ****************************************************************
`define ACD_OP_STBY_IMM0  8'hE0
`define ACD_OP_STBY_IMM1  8'h94
`define ACD_OP_IDLE_IMM0  8'hE1
`define ACD_OP_IDLE_IMM1  8'h95
`define ACD_OP_STBY0      8'hE2
`define ACD_OP_STBY1      8'h96
`define ACD_OP_IDLE0      8'hE3
`define ACD_OP_IDLE1      8'h97
`define ACD_OP_CHK_PWR0   8'hE5
`define ACD_OP_CHK_PWR1   8'h98
`define ACD_OP_SLEEP0     8'hE6
`define ACD_OP_SLEEP1     8'h99

// ****************************************************************
// security, smart and protected area opcodes
// ****************************************************************
`define ACD_OP_SEC_SETPW  8'hF1
`define ACD_OP_SEC_UNLK   8'hF2
`define ACD_OP_SEC_ERPRP  8'hF3
`define ACD_OP_SEC_ERASE  8'hF4
`define ACD_OP_SEC_FRZ    8'hF5
`define ACD_OP_SEC_DISPW  8'hF6
`define ACD_OP_SMART      8'hB0
`define ACD_OP_NATIVE_MAX 8'hF8
`define ACD_OP_SET_MAX    8'hF9

// ****************************************************************
// subcommand codes carried in the feature field
// ****************************************************************
`define ACD_SMART_RD_DATA 8'hD0
`define ACD_MAX_SET_PW    8'h01
`define ACD_MAX_UNLOCK    8'h03

// ****************************************************************
// transfer sizes
// ****************************************************************
`define ACD_IDENT_BYTES   10'h200
`define ACD_BYTES_W       10

`endif

// [hw/acd_subcmd.v]
// Purpose : sorts shared-opcode subcommands into data or non-data
// Assumes : feature code is stable while the opcode is presented
// Notes   : purely combinational, registered by the parent
`timescale 1ns/1ps
`include "acd_regs.vh"

module acd_subcmd (
    input  wire [7:0] opcode_in,
    input  wire [7:0] feature_in,
    output wire       shared_op_out,
    output wire [2:0] shared_cls_out
);

    // ****************************************************************
    // subcommand sorting
    // ****************************************************************
    wire is_smart  = (opcode_in == `ACD_OP_SMART);
    wire is_setmax = (opcode_in == `ACD_OP_SET_MAX);
    // only read-data moves data; every other smart feature is non-data
    wire smart_in  = is_smart && (feature_in == `ACD_SMART_RD_DATA);
    // password set and unlock carry a data block from the host
    wire max_out   = is_setmax && ((feature_in == `ACD_MAX_SET_PW) ||
                                   (feature_in == `ACD_MAX_UNLOCK));

    assign shared_op_out  = is_smart | is_setmax;
    assign shared_cls_out = smart_in ? `ACD_CLS_PIO_IN :
                            max_out  ? `ACD_CLS_PIO_OUT : `ACD_CLS_NONDATA;

endmodule // acd_subcmd

// [hw/acd_cmd_decoder.v]
// Purpose : sorts each ATA command code into its protocol class
// Assumes : command strobe, codes and engine status come from logic
//           on CLK_SYS_IN, so none of them is resynchronised
// Notes   : one command at a time; new strobes are ignored while busy
//           limitation: a strobe that lands while busy is dropped, not
//           queued, so the feeding logic must offer it again once idle
`timescale 1ns/1ps
`include "acd_regs.vh"

module acd_cmd_decoder (
    input  wire                    CLK_SYS_IN,
    input  wire                    RESET_IN,
    input  wire                    CMD_VALID_IN,
    input  wire [7:0]              CMD_CODE_IN,
    input  wire [7:0]              FEATURE_IN,
    input  wire                    ENGINE_DONE_IN,
    input  wire                    ENGINE_ERR_IN,
    output reg                     CMD_ACCEPT_OUT,
    output reg  [2:0]              CLASS_OUT,
    output reg  [7:0]              CMD_CODE_OUT,
    output reg  [`ACD_BYTES_W-1:0] XFER_BYTES_OUT,
    output reg                     FLUSH_REQ_OUT,
    output reg                     ABORT_OUT,
    output reg                     BUSY_OUT,
    output reg                     ERROR_OUT
);

    // ****************************************************************
    // states
    // ****************************************************************
    // one-hot; every supported command passes through busy
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;

    reg  [1:0] state;
    reg  [1:0] next_state;

    // ****************************************************************
    // single-code decode
    // ****************************************************************
    // returns the class of every opcode that owns its code outright;
    // shared codes and unknown codes fall through to abort here
    // one table keeps every single-code opcode in a single place; B0h and F9h are sorted in acd_subcmd
    function [2:0] class_of;
        input [7:0] op;
        begin
            case (op)
                `ACD_OP_RD_SEC0, `ACD_OP_RD_SEC1:
                    class_of = `ACD_CLS_PIO_IN;
                `ACD_OP_VFY0, `ACD_OP_VFY1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_WR_SEC0, `ACD_OP_WR_SEC1:
                    class_of = `ACD_CLS_PIO_OUT;
                `ACD_OP_CHK_PWR0, `ACD_OP_CHK_PWR1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_IDLE0, `ACD_OP_IDLE1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_IDLE_IMM0, `ACD_OP_IDLE_IMM1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_SLEEP0, `ACD_OP_SLEEP1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_STBY0, `ACD_OP_STBY1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_STBY_IMM0, `ACD_OP_STBY_IMM1:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_NATIVE_MAX:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_RD_DMA, `ACD_OP_WR_DMA:
                    class_of = `ACD_CLS_DMA;
                `ACD_OP_IDENT, `ACD_OP_RD_MULT, `ACD_OP_RD_BUF:
                    class_of = `ACD_CLS_PIO_IN;
                `ACD_OP_WR_MULT, `ACD_OP_WR_BUF:
                    class_of = `ACD_CLS_PIO_OUT;
                `ACD_OP_DIAG:
                    class_of = `ACD_CLS_DIAG;
                `ACD_OP_NOP, `ACD_OP_SET_FEAT, `ACD_OP_SET_MULT,
                `ACD_OP_FLUSH:
                    class_of = `ACD_CLS_NONDATA;
                `ACD_OP_SEC_SETPW, `ACD_OP_SEC_UNLK, `ACD_OP_SEC_ERASE,
                `ACD_OP_SEC_DISPW:
                    class_of = `ACD_CLS_PIO_OUT;
                `ACD_OP_SEC_ERPRP, `ACD_OP_SEC_FRZ:
                    class_of = `ACD_CLS_NONDATA;
                default:
                    class_of = `ACD_CLS_ABORT;
            endcase
        end
    endfunction

    // ****************************************************************
    // shared-opcode subcommands
    // ****************************************************************
    // the sorter is combinational; its answer is registered with the
    // class below, so the feature code only needs to stand with the strobe
    wire       shared_op;
    wire [2:0] shared_cls;

    acd_subcmd u_subcmd (
        .opcode_in      (CMD_CODE_IN),
        .feature_in     (FEATURE_IN),
        .shared_op_out  (shared_op),
        .shared_cls_out (shared_cls)
    );

    // ****************************************************************
    // final class and side effects of the incoming code
    // ****************************************************************
    // the feature field decides for B0h and F9h, the opcode elsewhere;
    // identify is the only code with a fixed transfer length
    wire [2:0] new_class = shared_op ? shared_cls
                                     : class_of(CMD_CODE_IN);
    wire       new_abort = (new_class == `ACD_CLS_ABORT);
    wire       new_flush = (CMD_CODE_IN == `ACD_OP_FLUSH);
    wire       new_ident = (CMD_CODE_IN == `ACD_OP_IDENT);

    // a strobe is only taken when no command is outstanding
    wire       take      = CMD_VALID_IN && (state == ST_IDLE);
    // done or error ends the outstanding command, flush included;
    // both pulses in one cycle count as an error end
    wire       finish    = (state == ST_BUSY) && (ENGINE_DONE_IN || ENGINE_ERR_IN);

    // ****************************************************************
    // next state
    // ****************************************************************
    // an aborted code never enters busy, so no transfer is started;
    // an unknown state code falls back to idle instead of locking up
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take && !new_abort) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (finish) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // state only; the outputs keep their own registers below
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // dispatch outputs
    // ****************************************************************
    // class and code hold until the next taken strobe, aborted ones included, so the engine
    // can read them at leisure; accept, flush and abort are pulses;
    // flush is only a pulse, busy carries the wait for the cache write
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CMD_ACCEPT_OUT <= 1'b0;
            CLASS_OUT      <= `ACD_CLS_NONDATA;
            CMD_CODE_OUT   <= 8'h00;
            XFER_BYTES_OUT <= {`ACD_BYTES_W{1'b0}};
            FLUSH_REQ_OUT  <= 1'b0;
            ABORT_OUT      <= 1'b0;
        end else begin
            CMD_ACCEPT_OUT <= take && !new_abort;
            FLUSH_REQ_OUT  <= take && new_flush;
            ABORT_OUT      <= take && new_abort;
            if (take) begin
                CLASS_OUT    <= new_class;
                CMD_CODE_OUT <= CMD_CODE_IN;
                // zero means length comes from the sector count
                XFER_BYTES_OUT <= new_ident ? `ACD_IDENT_BYTES
                                            : {`ACD_BYTES_W{1'b0}};
            end
        end
    end

    // ****************************************************************
    // busy and error flags
    // ****************************************************************
    // busy mirrors the busy state; error is sticky until next command;
    // take and finish never share a cycle, so set and clear cannot clash
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            BUSY_OUT  <= 1'b0;
            ERROR_OUT <= 1'b0;
        end else begin
            BUSY_OUT <= (next_state == ST_BUSY);
            if (take) begin
                ERROR_OUT <= new_abort;
            end else if (finish && ENGINE_ERR_IN) begin
                ERROR_OUT <= 1'b1;
            end
        end
    end

endmodule // acd_cmd_decoder

// [verification/acd_cmd_props.sv]
// Purpose : port assertions for the command protocol decoder
// Assumes : one clock, asynchronous active-high reset
// Notes   : bound to every decoder instance
`timescale 1ns/1ps

module acd_cmd_props (
    input wire       CLK_SYS_IN,
    input wire       RESET_IN,
    input wire       CMD_VALID_IN,
    input wire [7:0] CMD_CODE_IN,
    input wire [7:0] FEATURE_IN,
    input wire       ENGINE_DONE_IN,
    input wire       ENGINE_ERR_IN,
    input wire       CMD_ACCEPT_OUT,
    input wire [2:0] CLASS_OUT,
    input wire [7:0] CMD_CODE_OUT,
    input wire [9:0] XFER_BYTES_OUT,
    input wire       FLUSH_REQ_OUT,
    input wire       ABORT_OUT,
    input wire       BUSY_OUT,
    input wire       ERROR_OUT
);
    // ****************************************************************
    // command take, refusal and completion checks
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);

    wire take = CMD_VALID_IN && !BUSY_OUT;

    a_read_class: assert property (take && CMD_CODE_IN[7:1] == 7'h10 |=>
        CLASS_OUT == 3'h1) else $error("sector read not sorted as data-in");
    a_write_class: assert property (take && CMD_CODE_IN[7:1] == 7'h18 |=>
        CLASS_OUT == 3'h2) else $error("sector write not sorted as data-out");
    a_verify_nodata: assert property (take && CMD_CODE_IN[7:1] == 7'h20 |=>
        CLASS_OUT == 3'h0) else $error("verify not sorted as non-data");
    a_abort_flags: assert property (ABORT_OUT |->
        CLASS_OUT == 3'h5 && ERROR_OUT && !BUSY_OUT)
        else $error("abort without abort class, error or with busy");
    a_busy_ignore: assert property (CMD_VALID_IN && BUSY_OUT |=>
        $stable(CMD_CODE_OUT) && !CMD_ACCEPT_OUT && !ABORT_OUT)
        else $error("strobe taken while busy");
    a_busy_hold: assert property (BUSY_OUT && !ENGINE_DONE_IN && !ENGINE_ERR_IN |=>
        BUSY_OUT) else $error("busy dropped before engine finished");
    a_engine_end: assert property (BUSY_OUT && (ENGINE_DONE_IN || ENGINE_ERR_IN) |=>
        !BUSY_OUT && ERROR_OUT == $past(ENGINE_ERR_IN)) else $error("engine end not reflected");
    a_flush_req: assert property (FLUSH_REQ_OUT |-> CMD_CODE_OUT == 8'hE7 && BUSY_OUT)
        else $error("flush request without flush command");
    a_ident_bytes: assert property (CMD_ACCEPT_OUT |->
        (XFER_BYTES_OUT == 10'h200) == (CMD_CODE_OUT == 8'hEC)) else $error("byte count wrong");

    c_flush: cover property (FLUSH_REQ_OUT);
    c_abort: cover property (ABORT_OUT);
    c_err_end: cover property (BUSY_OUT && ENGINE_ERR_IN);
    c_refused: cover property (CMD_VALID_IN && BUSY_OUT);
endmodule // acd_cmd_props

bind acd_cmd_decoder acd_cmd_props u_props (
    .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .CMD_VALID_IN(CMD_VALID_IN),
    .CMD_CODE_IN(CMD_CODE_IN), .FEATURE_IN(FEATURE_IN), .ENGINE_DONE_IN(ENGINE_DONE_IN),
    .ENGINE_ERR_IN(ENGINE_ERR_IN), .CMD_ACCEPT_OUT(CMD_ACCEPT_OUT), .CLASS_OUT(CLASS_OUT),
    .CMD_CODE_OUT(CMD_CODE_OUT), .XFER_BYTES_OUT(XFER_BYTES_OUT),
    .FLUSH_REQ_OUT(FLUSH_REQ_OUT), .ABORT_OUT(ABORT_OUT), .BUSY_OUT(BUSY_OUT),
    .ERROR_OUT(ERROR_OUT));

// [verification/acd_engine_model.sv]
// Purpose : behavioural transfer engine behind the decoder
// Assumes : accept pulse starts one job, latency set per job
// Notes   : ends each job with a one-cycle done or error pulse
`timescale 1ns/1ps

module acd_engine_model (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       accept_in,
    input  wire [7:0] lat_in,
    input  wire       fail_in,
    output reg        done_out,
    output reg        err_out
);
    // ****************************************************************
    // job countdown
    // ****************************************************************
    reg [8:0] cnt;

    // pulses only once per job so a stuck done cannot hide a busy bug
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt      <= 9'h000;
            done_out <= 1'b0;
            err_out  <= 1'b0;
        end else begin
            done_out <= 1'b0;
            err_out  <= 1'b0;
            if (accept_in) begin
                cnt <= {1'b0, lat_in} + 9'h001;
            end else if (cnt == 9'h001) begin
                cnt      <= 9'h000;
                done_out <= !fail_in;
                err_out  <= fail_in;
            end else if (cnt != 9'h000) begin
                cnt <= cnt - 9'h001;
            end
        end
    end
endmodule // acd_engine_model

// [verification/test_ata_command_protocol_decoder.sv]
// Purpose : self-checking bench for the command protocol decoder
// Assumes : engine model answers every accepted command
// Notes   : table sweep, subcommand corners, then seeded random codes
`timescale 1ns/1ps

module test_ata_command_protocol_decoder;
    // ****************************************************************
    // stimulus, checks and verdict
    // ****************************************************************
    reg         clk, rst, valid, fail;
    reg  [7:0]  code, feat, lat;
    wire        done, err, accept, flush, abort_p, busy, error;
    wire [2:0]  cls;
    wire [7:0]  code_o;
    wire [9:0]  nbytes;
    integer     n_fail, samples_checked, i;
    reg [311:0] ops = {160'h90E7ECC8C420214041EFC6CAC5303100E4E8E598,
                       152'hE397E195E699E296E094F1F2F3F4F5F6B0F8F9};
    reg [127:0] subs = 128'hB0D0B0DAB0D4F901F903F900F902F904;

    acd_cmd_decoder dut_u (
        .CLK_SYS_IN(clk), .RESET_IN(rst), .CMD_VALID_IN(valid), .CMD_CODE_IN(code),
        .FEATURE_IN(feat), .ENGINE_DONE_IN(done), .ENGINE_ERR_IN(err),
        .CMD_ACCEPT_OUT(accept), .CLASS_OUT(cls), .CMD_CODE_OUT(code_o),
        .XFER_BYTES_OUT(nbytes), .FLUSH_REQ_OUT(flush), .ABORT_OUT(abort_p),
        .BUSY_OUT(busy), .ERROR_OUT(error));
    acd_engine_model eng_u (
        .clk_in(clk), .rst_in(rst), .accept_in(accept), .lat_in(lat),
        .fail_in(fail), .done_out(done), .err_out(err));

    always #2.5 clk = ~clk;

    // expected protocol class of a code and feature
    function [2:0] exp_cls(input [7:0] op, input [7:0] ft);
        case (op)
            8'h20, 8'h21, 8'hEC, 8'hC4, 8'hE4: exp_cls = 3'h1;
            8'h30, 8'h31, 8'hC5, 8'hE8, 8'hF1, 8'hF2, 8'hF4, 8'hF6: exp_cls = 3'h2;
            8'hC8, 8'hCA: exp_cls = 3'h3;
            8'h90: exp_cls = 3'h4;
            8'h40, 8'h41, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE5, 8'hE6, 8'hE7, 8'h94, 8'h95,
            8'h96, 8'h97, 8'h98, 8'h99, 8'h00, 8'hEF, 8'hC6, 8'hF3, 8'hF5, 8'hF8: exp_cls = 3'h0;
            8'hB0: exp_cls = (ft == 8'hD0) ? 3'h1 : 3'h0;
            8'hF9: exp_cls = (ft == 8'h01 || ft == 8'h03) ? 3'h2 : 3'h0;
            default: exp_cls = 3'h5;
        endcase
    endfunction

    task chk_v(input [9:0] g, input [9:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask

    task chk_f(input g, input e);
        begin
            chk_v({9'h000, g}, {9'h000, e});
        end
    endtask

    // one command; a busy-time strobe follows every accepted one
    task issue(input [7:0] op, input [7:0] ft);
        reg [2:0] ec;
        integer   k;
        begin
            ec = exp_cls(op, ft);
            @(posedge clk); #1;
            valid = 1'b1;
            code = op;
            feat = ft;
            lat = $urandom % 16;
            fail = ($urandom % 4) == 0;
            @(posedge clk); #1;
            code = $urandom % 256;
            if (ec == 3'h5) valid = 1'b0;
            chk_v(cls, ec);
            chk_f(abort_p, ec == 3'h5);
            chk_f(accept, ec != 3'h5);
            chk_f(error, ec == 3'h5);
            chk_f(busy, ec != 3'h5);
            if (ec != 3'h5) begin
                chk_v(nbytes, (op == 8'hEC) ? 10'h200 : 10'h000);
                chk_f(flush, op == 8'hE7);
                @(posedge clk); #1;
                valid = 1'b0;
                chk_v(code_o, op);
                chk_f(accept, 1'b0);
                for (k = 0; k < 40 && busy === 1'b1; k = k + 1) begin
                    @(posedge clk); #1;
                end
                chk_f(busy, 1'b0);
                chk_f(error, fail);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        valid = 1'b0;
        fail = 1'b0;
        code = 8'h00;
        feat = 8'h00;
        lat = 8'h00;
        n_fail = 0;
        samples_checked = 0;
        i = $urandom(3);
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 0; i < 39; i = i + 1)
            issue(ops[8*i +: 8], 8'h00);
        for (i = 0; i < 8; i = i + 1)
            issue(subs[16*i+8 +: 8], subs[16*i +: 8]);
        for (i = 0; i < 200; i = i + 1) issue($urandom % 256, $urandom % 256);
        print_verdict;
    end

    // watchdog well beyond the longest expected run
    initial begin
        #300000;
        n_fail = n_fail + 1;
        print_verdict;
    end
endmodule // test_ata_command_protocol_decoder
